/* File: bec_pkg.sv */
// ****************************************************************
// Constants for the bridge error and clock-run register bank
// ****************************************************************
package bec_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CAUSE = 8'h68; // Error cause flags word
    localparam logic [7:0] OFS_CLOCK_RUN_CONTROL = 8'h6c; // Clock-run control word
    localparam logic [7:0] OFS_PORT_OPT = 8'h74; // Port option word
    localparam logic [7:0] OFS_IRQ_MASK = 8'h78; // Interrupt mask word

    // ************************************************************
    // Field positions inside the 32-bit words
    // ************************************************************
    localparam int CAUSE_LSB = 16; // Cause flags occupy 23:16
    localparam int CAUSE_W = 8; // Eight cause flags
    localparam int BIT_SEC_STOPPED = 24; // Secondary clock stopped
    localparam int BIT_SEC_RUN_EN = 25; // Secondary clock-run enable
    localparam int BIT_PRI_KEEP = 26; // Keep primary clock running
    localparam int BIT_PRI_RUN_EN = 27; // Primary clock-run enable
    localparam int BIT_RUN_MODE = 28; // Idle-stop mode
    localparam int BIT_RD_ALIAS = 1; // Read alias enable
    localparam int BIT_WR_ALIAS = 2; // Write alias enable
    localparam int BIT_PIN_SEEN = 8; // Error pin observed low

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_CAUSE = 8'h00; // Flags clear
    localparam logic [7:0] RST_IRQ_MASK = 8'h00; // All masked
    localparam logic RST_CTRL_BIT = 1'b0; // Clock-run bits
    localparam logic RST_RD_ALIAS = 1'b1; // Read alias on
    localparam logic RST_WR_ALIAS = 1'b0; // Write alias off

    // ************************************************************
    // Bus command codes
    // ************************************************************
    localparam logic [3:0] PLAIN_MEMORY_READ_CMD = 4'h6;
    localparam logic [3:0] PLAIN_MEMORY_WRITE_CMD = 4'h7;
    localparam logic [3:0] MEMORY_READ_MULTIPLE_CMD = 4'hc;
    localparam logic [3:0] MEMORY_READ_LINE_CMD = 4'he;
    localparam logic [3:0] MEMORY_WRITE_INVALIDATE_CMD = 4'hf;

    // ************************************************************
    // Secondary clock states
    // ************************************************************
    typedef enum logic [0:0] {
        BEC_CLK_RUN = 1'b0,
        BEC_CLK_STOP = 1'b1
    } bec_clk_state_t;

endpackage : bec_pkg

/* File: bec_regs.sv */
// How it works
// RULE_01: Address parity error sets cause bit 16.
// RULE_02: Posted write data parity sets bit 17.
// RULE_03: Posted write non-delivery sets bit 18.
// RULE_04: Posted write target abort sets bit 19.
// RULE_05: Posted write master abort sets bit 20.
// RULE_06: Delayed write non-delivery sets bit 21.
// RULE_07: Delayed read without data sets bit 22.
// RULE_08: Delayed transaction master timeout sets bit 23.
// RULE_09: Flags reset zero, cleared only by one.
// RULE_10: Bit 24 reports secondary clock stopped.
// RULE_11: Bit 25 enables secondary clock-run, resets zero.
// RULE_12: Bit 27 enables primary clock-run, resets zero.
// RULE_13: Bit 26 one keeps primary clock running.
// RULE_14: Bit 28 selects request or idle stopping.
// RULE_15: Bit 1 aliases read line/multiple to read.
// RULE_16: Bit 2 aliases write-invalidate to write.
// RULE_17: Reserved bits read zero, not writable.
// RULE_18: Error pin needs enable and clear disable.
// RULE_19: Initiators repeat retried requests before timeout.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module bec_regs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] cause_event,
    input wire logic serr_enable,
    input wire logic [7:0] event_disable,
    input wire logic sec_bus_idle,
    input wire logic pri_stop_request,
    input wire logic pri_request_pending,
    input wire logic retry_check,
    input wire logic [3:0] retry_cmd,
    input wire logic [3:0] held_cmd,
    output logic cmd_match,
    output logic cmd_match_valid,
    input wire logic primary_system_error_pin_i,
    output logic primary_system_error_pin_o,
    output logic primary_system_error_pin_oe_n,
    output logic sec_clock_stopped,
    output logic pri_clock_stop_allow,
    output logic irq
);

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic [1:0] rst_sync_q; // Two-stage release
    logic rst_n; // Synchronised reset
    // Release reset on the clock, assert it at once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] cause_q; // Sticky error cause flags
    logic [7:0] irq_mask_q; // Interrupt mask
    logic sec_run_en_q; // Secondary clock-run enable
    logic pri_keep_q; // Keep primary clock running
    logic pri_run_en_q; // Primary clock-run enable
    logic run_mode_q; // Idle-stop mode
    logic rd_alias_q; // Read command alias
    logic wr_alias_q; // Write command alias
    bec_pkg::bec_clk_state_t clk_state_q; // Secondary clock state
    bec_pkg::bec_clk_state_t clk_state_d; // Next clock state
    logic [2:0] pin_sync_q; // Error pin synchroniser
    logic pin_seen_q; // Pin observed low, filtered

    // ************************************************************
    // Decode and event qualification
    // ************************************************************
    logic wr_cause; // Write to cause word
    logic wr_clock_run_control; // Write to clock-run word
    logic wr_port; // Write to port option word
    logic wr_mask; // Write to mask word
    logic [7:0] allow; // Per-event pin permission
    logic [7:0] flag_set; // Events that raise the pin
    logic [7:0] flag_clr; // Write-one-to-clear mask
    assign wr_cause = reg_wr && (reg_addr == bec_pkg::OFS_CAUSE);
    assign wr_clock_run_control = reg_wr && (reg_addr == bec_pkg::OFS_CLOCK_RUN_CONTROL);
    assign wr_port = reg_wr && (reg_addr == bec_pkg::OFS_PORT_OPT);
    assign wr_mask = reg_wr && (reg_addr == bec_pkg::OFS_IRQ_MASK);
    // Events without a disable bit depend on the enable alone
    assign allow = {1'b1, ~event_disable[6:1], 1'b1}; // [RULE_18]
    assign flag_set = cause_event & allow & {8{serr_enable}}; // [RULE_18]
    assign flag_clr = wr_cause ?
        reg_wdata[bec_pkg::CAUSE_LSB +: bec_pkg::CAUSE_W] : 8'h00;

    // ************************************************************
    // Cause flags
    // ************************************************************
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cause_q <= bec_pkg::RST_CAUSE; // [RULE_09]
        end else if (clk_en) begin
            // Bits 16..23 in order of cause_event [RULE_01] [RULE_02]
            // [RULE_03] [RULE_04] [RULE_05] [RULE_06] [RULE_07] [RULE_08]
            cause_q <= (cause_q & ~flag_clr) | flag_set; // [RULE_09]
        end
    end

    // ************************************************************
    // Error pin driver, open drain
    // ************************************************************
    // Pulls the pin low for one cycle after each cycle holding a qualified event
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            primary_system_error_pin_oe_n <= 1'b1;
            primary_system_error_pin_o <= 1'b0;
        end else if (clk_en) begin
            primary_system_error_pin_oe_n <= ~(|flag_set); // [RULE_18]
            primary_system_error_pin_o <= 1'b0;
        end
    end

    // Pin level seen from outside, three stages
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_q <= 3'h7;
            pin_seen_q <= 1'b0;
        end else if (clk_en) begin
            pin_sync_q <= {pin_sync_q[1:0], primary_system_error_pin_i};
            // Change taken once second and third stages agree
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_seen_q <= ~pin_sync_q[2];
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    // Clock-run fields, reserved bits are never stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_run_en_q <= bec_pkg::RST_CTRL_BIT; // [RULE_11]
            pri_keep_q <= bec_pkg::RST_CTRL_BIT;
            pri_run_en_q <= bec_pkg::RST_CTRL_BIT; // [RULE_12]
            run_mode_q <= bec_pkg::RST_CTRL_BIT;
        end else if (clk_en && wr_clock_run_control) begin
            sec_run_en_q <= reg_wdata[bec_pkg::BIT_SEC_RUN_EN]; // [RULE_11]
            pri_keep_q <= reg_wdata[bec_pkg::BIT_PRI_KEEP];
            pri_run_en_q <= reg_wdata[bec_pkg::BIT_PRI_RUN_EN]; // [RULE_12]
            run_mode_q <= reg_wdata[bec_pkg::BIT_RUN_MODE];
        end
    end

    // Alias enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_alias_q <= bec_pkg::RST_RD_ALIAS; // [RULE_15]
            wr_alias_q <= bec_pkg::RST_WR_ALIAS; // [RULE_16]
        end else if (clk_en && wr_port) begin
            rd_alias_q <= reg_wdata[bec_pkg::BIT_RD_ALIAS];
            wr_alias_q <= reg_wdata[bec_pkg::BIT_WR_ALIAS];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= bec_pkg::RST_IRQ_MASK;
        end else if (clk_en && wr_mask) begin
            irq_mask_q <= reg_wdata[7:0];
        end
    end

    // ************************************************************
    // Secondary clock stop machine
    // ************************************************************
    // Mode picks idle-driven or request-driven stopping
    always_comb begin
        clk_state_d = bec_pkg::BEC_CLK_RUN;
        case (clk_state_q)
            bec_pkg::BEC_CLK_RUN, bec_pkg::BEC_CLK_STOP: begin // Stop or hold
                if (sec_run_en_q && (run_mode_q ?
                    (sec_bus_idle && !pri_request_pending) :
                    pri_stop_request)) begin // [RULE_14]
                    clk_state_d = bec_pkg::BEC_CLK_STOP;
                end
            end
            default: begin
                clk_state_d = bec_pkg::BEC_CLK_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_state_q <= bec_pkg::BEC_CLK_RUN; // [RULE_10]
        end else if (clk_en) begin
            clk_state_q <= clk_state_d;
        end
    end

    // Clock outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sec_clock_stopped <= 1'b0;
            pri_clock_stop_allow <= 1'b0;
        end else if (clk_en) begin
            sec_clock_stopped <= (clk_state_d == bec_pkg::BEC_CLK_STOP);
            // Primary may stop only behind a stopped secondary
            pri_clock_stop_allow <= pri_run_en_q && !pri_keep_q &&
                (clk_state_d == bec_pkg::BEC_CLK_STOP); // [RULE_13]
        end
    end

    // ************************************************************
    // Retry command matching
    // ************************************************************
    // Folds aliased commands onto their plain form
    function automatic logic [3:0] bec_fold(input logic [3:0] cmd,
                                            input logic rd_al,
                                            input logic wr_al);
        logic [3:0] res;
        res = cmd;
        if (rd_al && (cmd == bec_pkg::MEMORY_READ_LINE_CMD ||
            cmd == bec_pkg::MEMORY_READ_MULTIPLE_CMD)) begin
            res = bec_pkg::PLAIN_MEMORY_READ_CMD; // [RULE_15]
        end else if (wr_al &&
            cmd == bec_pkg::MEMORY_WRITE_INVALIDATE_CMD) begin
            res = bec_pkg::PLAIN_MEMORY_WRITE_CMD; // [RULE_16]
        end
        return res;
    endfunction : bec_fold

    // Answer one cycle after each check
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_match <= 1'b0;
            cmd_match_valid <= 1'b0;
        end else if (clk_en) begin
            cmd_match_valid <= retry_check;
            if (retry_check) begin
                cmd_match <= bec_fold(retry_cmd, rd_alias_q, wr_alias_q) ==
                    bec_fold(held_cmd, rd_alias_q, wr_alias_q);
            end
        end
    end

    // ************************************************************
    // Read port and interrupt
    // ************************************************************
    // Read data one cycle later, unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= 32'h0000_0000; // [RULE_17]
            if (reg_rd && reg_addr == bec_pkg::OFS_CAUSE) begin
                reg_rdata[bec_pkg::CAUSE_LSB +: bec_pkg::CAUSE_W] <= cause_q;
            end else if (reg_rd && reg_addr == bec_pkg::OFS_CLOCK_RUN_CONTROL) begin
                reg_rdata[bec_pkg::BIT_SEC_STOPPED] <=
                    (clk_state_q == bec_pkg::BEC_CLK_STOP); // [RULE_10]
                reg_rdata[bec_pkg::BIT_SEC_RUN_EN] <= sec_run_en_q;
                reg_rdata[bec_pkg::BIT_PRI_KEEP] <= pri_keep_q;
                reg_rdata[bec_pkg::BIT_PRI_RUN_EN] <= pri_run_en_q;
                reg_rdata[bec_pkg::BIT_RUN_MODE] <= run_mode_q;
            end else if (reg_rd && reg_addr == bec_pkg::OFS_PORT_OPT) begin
                reg_rdata[bec_pkg::BIT_RD_ALIAS] <= rd_alias_q;
                reg_rdata[bec_pkg::BIT_WR_ALIAS] <= wr_alias_q;
            end else if (reg_rd && reg_addr == bec_pkg::OFS_IRQ_MASK) begin
                reg_rdata[7:0] <= irq_mask_q;
                reg_rdata[bec_pkg::BIT_PIN_SEEN] <= pin_seen_q;
            end
        end
    end

    // Level interrupt from unmasked flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(((cause_q & ~flag_clr) | flag_set) & irq_mask_q);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_addr_parity_flag: assert property ( // [RULE_01]
        clk_en && cause_event[0] && serr_enable |=> cause_q[0])
        else $error("Address parity flag not set");
    a_posted_parity_flag: assert property ( // [RULE_02]
        clk_en && cause_event[1] && serr_enable && !event_disable[1]
        |=> cause_q[1])
        else $error("Posted parity flag not set");
    a_posted_nodeliv_flag: assert property ( // [RULE_03]
        clk_en && cause_event[2] && serr_enable && !event_disable[2]
        |=> cause_q[2])
        else $error("Posted non-delivery flag not set");
    a_target_abort_flag: assert property ( // [RULE_04]
        clk_en && cause_event[3] && serr_enable && !event_disable[3]
        |=> cause_q[3])
        else $error("Target abort flag not set");
    a_master_abort_flag: assert property ( // [RULE_05]
        clk_en && cause_event[4] && serr_enable && !event_disable[4]
        |=> cause_q[4])
        else $error("Master abort flag not set");
    a_delayed_wr_flag: assert property ( // [RULE_06]
        clk_en && cause_event[5] && serr_enable && !event_disable[5]
        |=> cause_q[5])
        else $error("Delayed write flag not set");
    a_delayed_rd_flag: assert property ( // [RULE_07]
        clk_en && cause_event[6] && serr_enable && !event_disable[6]
        |=> cause_q[6])
        else $error("Delayed read flag not set");
    a_timeout_flag: assert property ( // [RULE_08]
        clk_en && cause_event[7] && serr_enable |=> cause_q[7])
        else $error("Master timeout flag not set");
    a_flag_w1c_hold: assert property ( // [RULE_09]
        clk_en && !flag_set[0] && cause_q[0] && !flag_clr[0] |=> cause_q[0])
        else $error("Flag dropped without a one written");
    a_stop_status_read: assert property ( // [RULE_10]
        reg_rd && clk_en && reg_addr == bec_pkg::OFS_CLOCK_RUN_CONTROL
        |=> reg_rdata[bec_pkg::BIT_SEC_STOPPED] == $past(sec_clock_stopped))
        else $error("Stop status differs from clock state");
    a_sec_disabled_runs: assert property ( // [RULE_11]
        clk_en && !sec_run_en_q |=> !sec_clock_stopped)
        else $error("Secondary clock stopped while disabled");
    a_pri_keep_run: assert property ( // [RULE_13] [RULE_12]
        clk_en && (pri_keep_q || !pri_run_en_q) |=> !pri_clock_stop_allow)
        else $error("Primary clock allowed to stop");
    a_idle_mode_stop: assert property ( // [RULE_14]
        clk_en && sec_run_en_q && run_mode_q && sec_bus_idle &&
        !pri_request_pending |=> sec_clock_stopped)
        else $error("Idle mode did not stop clock");
    a_read_alias_match: assert property ( // [RULE_15]
        clk_en && retry_check && rd_alias_q &&
        retry_cmd == bec_pkg::MEMORY_READ_LINE_CMD &&
        held_cmd == bec_pkg::PLAIN_MEMORY_READ_CMD |=> cmd_match)
        else $error("Read alias not matched");
    a_write_exact_match: assert property ( // [RULE_16]
        clk_en && retry_check && !wr_alias_q &&
        retry_cmd == bec_pkg::MEMORY_WRITE_INVALIDATE_CMD &&
        held_cmd == bec_pkg::PLAIN_MEMORY_WRITE_CMD |=> !cmd_match)
        else $error("Write alias matched while off");
    a_reserved_zero: assert property ( // [RULE_17]
        clk_en && reg_rd && reg_addr == bec_pkg::OFS_CLOCK_RUN_CONTROL
        |=> reg_rdata[31:29] == 3'h0 && reg_rdata[23:0] == 24'h0)
        else $error("Reserved bits read non-zero");
    a_pin_gated: assert property ( // [RULE_18]
        clk_en && !serr_enable |=> primary_system_error_pin_oe_n)
        else $error("Error pin driven while disabled");

    c_flag_set_clear: cover property (
        cause_q[0] ##1 clk_en && flag_clr[0] ##1 !cause_q[0]);
    c_sec_stop: cover property (!sec_clock_stopped ##1 sec_clock_stopped);
    c_pri_allow: cover property (pri_clock_stop_allow);
    c_irq_raised: cover property (!irq ##1 irq);

endmodule : bec_regs

/* File: bec_far_end.sv */
`timescale 1ns/1ns
// ****************************************************************
// Far side: error detectors and the pulled-up system-error pin
// ****************************************************************
module bec_far_end (
    input wire logic fire,
    input wire logic [2:0] fire_idx,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    output logic [7:0] cause_event,
    output logic pin_wire
);
    // One-hot detector pulse; index 7 is an initiator missing its repeat
    assign cause_event = fire ? (8'h01 << fire_idx) : 8'h00;
    // Pull-up holds the wire high whenever nobody drives it
    assign pin_wire = pin_oe_n ? 1'b1 : pin_o;
endmodule : bec_far_end

/* File: bridge_error_clock_alias_regs_tb.sv */
`timescale 1ns/1ns
module bridge_error_clock_alias_regs_tb;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, event_disable = 8'h00, cause_event;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v, c;
    logic serr_enable = 1'b0, idle = 1'b0, pend = 1'b0, req = 1'b0;
    logic retry_check = 1'b0, fire = 1'b0, pin_wire, pin_o, oe_n, q;
    logic en = 1'b1; // Clock enable, lowered once
    logic [3:0] retry_cmd = 4'h0, held_cmd = 4'h0;
    logic [2:0] fire_idx = 3'h0;
    logic cmd_match, cmd_match_valid, stopped, allow, irq, exp_stop;
    logic [3:0] cmds [5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    int err_count = 0, checks_done = 0;
    always #5 clk_sys = ~clk_sys;
    // Design and far-side model
    bec_regs dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cause_event(cause_event),
        .serr_enable(serr_enable), .event_disable(event_disable),
        .sec_bus_idle(idle), .pri_stop_request(req),
        .pri_request_pending(pend), .retry_check(retry_check),
        .retry_cmd(retry_cmd), .held_cmd(held_cmd), .cmd_match(cmd_match),
        .cmd_match_valid(cmd_match_valid),
        .primary_system_error_pin_i(pin_wire),
        .primary_system_error_pin_o(pin_o),
        .primary_system_error_pin_oe_n(oe_n), .sec_clock_stopped(stopped),
        .pri_clock_stop_allow(allow), .irq(irq));
    bec_far_end far_u (.fire(fire), .fire_idx(fire_idx), .pin_o(pin_o),
        .pin_oe_n(oe_n), .cause_event(cause_event), .pin_wire(pin_wire));
    // ************************************************************
    // Tasks and reference functions
    // ************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Command folding under the two alias bits
    function automatic logic [3:0] fold(input logic [3:0] k,
                                        input logic ra, input logic wa);
        if (ra && (k == 4'hc || k == 4'he)) return 4'h6;
        if (wa && k == 4'hf) return 4'h7;
        return k;
    endfunction : fold
    task automatic conclude();
        $display("Counts: checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Watchdog against hangs
    initial begin
        #400000;
        err_count++;
        conclude();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h40017067));
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // Reset values, reserved space, unmapped place
        rd(8'h68, v); chk(v, 32'h0);
        rd(8'h6c, v); chk(v, 32'h0);
        rd(8'h74, v); chk(v, 32'h2);
        wr(8'h70, 32'hffffffff);
        rd(8'h70, v); chk(v, 32'h0);
        // A write while the clock enable is low must not land
        @(posedge clk_sys);
        en <= 1'b0;
        wr(8'h74, 32'h0);
        en <= 1'b1;
        rd(8'h74, v); chk(v, 32'h2);
        $display("test reset_values done");
        // Each cause event, gated, masked, then cleared
        for (int i = 0; i < 8; i++) begin
            c = $urandom;
            wr(8'h78, c);
            @(posedge clk_sys);
            event_disable <= c[15:8];
            serr_enable <= (i < 2) ? 1'b1 : c[16];
            fire <= 1'b1;
            fire_idx <= i[2:0];
            @(posedge clk_sys);
            fire <= 1'b0;
            q = serr_enable && (i == 0 || i == 7 || !c[8 + i]);
            #1 chk(oe_n, !q);
            chk(pin_wire, !q);
            chk(irq, q && c[i]);
            rd(8'h68, v);
            chk(v, {8'h0, q, 23'h0} >> (7 - i)); // to
            wr(8'h68, 32'h0);
            rd(8'h68, v); chk(v, {8'h0, q, 23'h0} >> (7 - i));
            wr(8'h68, 32'h1 << (16 + i));
            rd(8'h68, v); chk(v, 32'h0);
            chk(irq, 1'b0);
        end
        $display("test cause_flags done");
        // Clock-run control under random settings and bus states
        for (int i = 0; i < 32; i++) begin
            c = $urandom;
            wr(8'h6c, c);
            idle <= c[0];
            pend <= c[1];
            req <= c[2];
            repeat (2) @(posedge clk_sys);
            exp_stop = c[25] && (c[28] ? (c[0] && !c[1]) : c[2]);
            #1 chk(stopped, exp_stop);
            chk(allow, c[27] && !c[26] && exp_stop);
            rd(8'h6c, v);
            chk(v, {3'h0, c[28:25], exp_stop, 24'h0});
        end
        $display("test clock_run done");
        // Alias selection and retry command matching
        for (int i = 0; i < 24; i++) begin
            c = $urandom;
            wr(8'h74, c);
            rd(8'h74, v); chk(v, c & 32'h6);
            @(posedge clk_sys);
            retry_cmd <= cmds[$urandom % 5];
            held_cmd <= cmds[$urandom % 5];
            retry_check <= 1'b1;
            @(posedge clk_sys);
            retry_check <= 1'b0;
            #1 chk(cmd_match_valid, 1'b1);
            chk(cmd_match, fold(retry_cmd, c[1], c[2]) ==
                fold(held_cmd, c[1], c[2]));
        end
        $display("test cmd_alias done");
        conclude();
    end
endmodule : bridge_error_clock_alias_regs_tb
